// >>> rtl/dsm_symbol_mapper.sv
`default_nettype none
module dsm_symbol_mapper #(
  parameter int MEAS_W = dsm_pkg::PWR_MEAS_W,
  parameter int LEVEL_W = dsm_pkg::PWR_LEVEL_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tx_start,
  input wire logic in_valid,
  input wire dsm_pkg::dsm_bit_t in_sym,
  output logic in_ready,
  input wire dsm_pkg::dsm_rate_t payload_rate,
  input wire logic header_short,
  input wire logic tx_filter_select_config,
  input wire logic [MEAS_W-1:0] tx_power_adc,
  output logic [MEAS_W-1:0] tx_power_measurement,
  input wire logic [LEVEL_W-1:0] tx_power_level_request,
  output logic [LEVEL_W-1:0] tx_power_level,
  output logic chip_valid,
  output logic out_valid,
  output dsm_pkg::dsm_iq_t out_iq
);
  import dsm_pkg::*;

  typedef enum logic [1:0] {
    ST_GATHER = 2'b01,
    ST_SEND = 2'b10
  } dsm_state_t;

  dsm_state_t state;
  dsm_state_t next_state;
  dsm_rate_t sym_mode;
  logic [7:0] sym_bits;
  logic [3:0] bit_cnt;
  logic [3:0] chip_idx;
  logic [1:0] phase;
  logic [1:0] p2;
  logic [1:0] p3;
  logic [1:0] p4;
  logic payload_odd;

  // Symbol assembly
  dsm_rate_t bit_mode;
  dsm_rate_t cur_mode;
  logic [3:0] need;
  logic [3:0] bit_cnt_inc;
  logic [7:0] bits_now;
  logic take;
  logic last_bit;

  assign bit_mode = (in_sym.seg == SEG_PREAMBLE) ? RATE_1M :
                    (in_sym.seg == SEG_HEADER) ? (header_short ? RATE_2M : RATE_1M) :
                    payload_rate;
  assign cur_mode = (bit_cnt == 4'h0) ? bit_mode : sym_mode;
  assign need = (cur_mode == RATE_1M) ? BITS_1M :
                (cur_mode == RATE_2M) ? BITS_2M :
                (cur_mode == RATE_5M5) ? BITS_5M5 : BITS_11M;
  // A packet start blocks intake for one cycle so no bit meets stale state
  assign in_ready = (state == ST_GATHER) && !tx_start;
  assign take = in_valid && in_ready;
  assign bit_cnt_inc = 4'(bit_cnt + 4'h1);
  assign last_bit = take && (bit_cnt_inc == need);

  always_comb begin
    bits_now = sym_bits;
    bits_now[bit_cnt[2:0]] = in_sym.data;
  end

  // Phase change of the reference phase
  logic [1:0] dq_step;
  logic [1:0] dphi;
  logic [1:0] new_phase;
  logic is_cck;
  logic odd_rot;

  assign is_cck = (cur_mode == RATE_5M5) || (cur_mode == RATE_11M);
  assign dq_step = {bits_now[0], bits_now[0] ^ bits_now[1]};
  assign odd_rot = is_cck && payload_odd;
  assign dphi = (cur_mode == RATE_1M) ? {bits_now[0], 1'b0} :
                (cur_mode == RATE_2M) ? dq_step :
                2'(dq_step + (odd_rot ? PH_HALF : PH_ZERO));
  // One reference carries across rate changes into the CCK payload
  assign new_phase = 2'(phase + dphi);

  // Code word phases for CCK
  logic [1:0] next_p2;
  logic [1:0] next_p3;
  logic [1:0] next_p4;

  assign next_p2 = (cur_mode == RATE_5M5) ? {bits_now[2], 1'b1} : {bits_now[2], bits_now[3]};
  assign next_p3 = (cur_mode == RATE_5M5) ? PH_ZERO : {bits_now[4], bits_now[5]};
  assign next_p4 = (cur_mode == RATE_5M5) ? {bits_now[3], 1'b0} : {bits_now[6], bits_now[7]};

  // Chip generation
  logic send_cck;
  logic [2:0] cidx;
  logic [1:0] barker_q;
  logic [1:0] cck_q;
  logic [1:0] chip_q;
  logic chip_last;
  logic i_neg;
  logic q_neg;

  assign send_cck = (sym_mode == RATE_5M5) || (sym_mode == RATE_11M);
  assign cidx = chip_idx[2:0];
  assign barker_q = 2'(phase + (BARKER_NEG[chip_idx] ? PH_HALF : PH_ZERO));
  assign cck_q = 2'(phase
                    + (cidx[0] ? PH_ZERO : p2)
                    + (cidx[1] ? PH_ZERO : p3)
                    + (cidx[2] ? PH_ZERO : p4)
                    + ((cidx == CCK_NEG_A || cidx == CCK_NEG_B) ? PH_HALF : PH_ZERO));
  assign chip_q = send_cck ? cck_q : barker_q;
  assign chip_last = chip_idx == (send_cck ? CCK_LAST : BARKER_LAST);
  assign chip_valid = (state == ST_SEND);
  // Constellation rotated by 45 degrees so every chip is a plain +-1 pair
  assign i_neg = chip_q[1] ^ chip_q[0];
  assign q_neg = chip_q[1];

  always_comb begin
    case (state)
      ST_GATHER: next_state = last_bit ? ST_SEND : ST_GATHER;
      ST_SEND: next_state = chip_last ? ST_GATHER : ST_SEND;
      default: next_state = ST_GATHER;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || tx_start) begin
      state <= ST_GATHER;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || tx_start) begin
      bit_cnt <= 4'h0;
      sym_bits <= 8'h00;
      sym_mode <= RATE_1M;
    end else if (last_bit) begin
      bit_cnt <= 4'h0;
      sym_bits <= bits_now;
      sym_mode <= cur_mode;
    end else if (take) begin
      bit_cnt <= bit_cnt_inc;
      sym_bits <= bits_now;
      sym_mode <= cur_mode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || tx_start) begin
      phase <= PH_ZERO;
      payload_odd <= 1'b0;
      p2 <= PH_ZERO;
      p3 <= PH_ZERO;
      p4 <= PH_ZERO;
    end else if (last_bit) begin
      phase <= new_phase;
      p2 <= next_p2;
      p3 <= next_p3;
      p4 <= next_p4;
      if (in_sym.seg == SEG_PAYLOAD) begin
        payload_odd <= !payload_odd;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || tx_start) begin
      chip_idx <= 4'h0;
    end else if (state == ST_SEND) begin
      chip_idx <= chip_last ? 4'h0 : 4'(chip_idx + 4'h1);
    end
  end

  // Shaping filter; each delay stage holds {chip present, chip negative}
  logic [2*FIR_TAPS-1:0] dl_i;
  logic [2*FIR_TAPS-1:0] dl_q;
  logic signed [SAMPLE_W-1:0] term_i [FIR_TAPS];
  logic signed [SAMPLE_W-1:0] term_q [FIR_TAPS];
  logic signed [SAMPLE_W-1:0] next_sum_i;
  logic signed [SAMPLE_W-1:0] next_sum_q;
  logic [FIR_TAPS-1:0] tap_active;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dl_i <= '0;
      dl_q <= '0;
    end else begin
      dl_i <= {dl_i[2*FIR_TAPS-3:0], chip_valid, chip_valid & i_neg};
      dl_q <= {dl_q[2*FIR_TAPS-3:0], chip_valid, chip_valid & q_neg};
    end
  end

  genvar k;
  for (k = 0; k < FIR_TAPS; k++) begin : g_tap
    logic signed [SAMPLE_W-1:0] coef;
    // Wide shape gains bandwidth and about 1.6 dB of output power
    assign coef = SAMPLE_W'(tx_filter_select_config ? FIR_WIDE[k] : FIR_STD[k]);
    assign tap_active[k] = dl_i[2*k+1];
    assign term_i[k] = !dl_i[2*k+1] ? '0 : (dl_i[2*k] ? -coef : coef);
    assign term_q[k] = !dl_q[2*k+1] ? '0 : (dl_q[2*k] ? -coef : coef);
  end

  always_comb begin
    next_sum_i = '0;
    next_sum_q = '0;
    for (int t = 0; t < FIR_TAPS; t++) begin
      next_sum_i = SAMPLE_W'(next_sum_i + term_i[t]);
      next_sum_q = SAMPLE_W'(next_sum_q + term_q[t]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_iq <= '0;
      out_valid <= 1'b0;
    end else begin
      out_iq.i <= next_sum_i;
      out_iq.q <= next_sum_q;
      out_valid <= |tap_active;
    end
  end

  // Power measurement from the converter; the word must be held steady
  // for two clocks since the bits are synchronised independently
  logic [MEAS_W-1:0] adc_meta;
  logic [MEAS_W-1:0] adc_sync;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      adc_meta <= '0;
      adc_sync <= '0;
      tx_power_measurement <= '0;
      tx_power_level <= '0;
    end else begin
      adc_meta <= tx_power_adc;
      adc_sync <= adc_meta;
      tx_power_measurement <= adc_sync;
      tx_power_level <= tx_power_level_request;
    end
  end
endmodule : dsm_symbol_mapper
`default_nettype wire

// >>> common/dsm_pkg.sv
// Notes on behaviour
// - Rates 1, 2, 5.5, 11 Mbps; preamble DBPSK, header/payload switch automatically.
// - 1 Mbps: I and Q equal, or opposite once a 2 Mbps header leaves the phase odd; differential bit, spread by 11-chip Barker.
// - 2 Mbps: differential dibits, one bit to I, one to Q, Barker spread.
// - Dibit phase change: 00 0, 01 +90, 11 +180, 10 -90, counterclockwise.
// - Chips pass through a tap-coefficient FIR shaping filter.
// - A config bit selects a wider main lobe filter shape.
// - CCK symbols spread into eight complex chips.
// - CCK chip phases follow the complementary code word formula.
// - CCK chips go out index 0 first, reference-phase chip last.
// - CCK p1 is differential against the previous symbol p1.
// - p1 dibit map as DQPSK; odd symbols get an extra pi.
// - Payload symbols count from zero, so payload starts even.
// - 5.5 Mbps: 4-bit groups, two bits p1, two bits select code word.
// - 5.5 Mbps: p2 = d2*pi + pi/2, p3 = 0, p4 = d3*pi.
// - 11 Mbps: eight bits, first dibit p1, then p2, p3, p4.
// - p2..p4 dibits are binary coded: 00 0, 01 pi/2, 10 pi, 11 3pi/2.
// - Measured transmit power is digitized and held for the MAC to read.
`default_nettype none
package dsm_pkg;
  typedef enum logic [1:0] {
    RATE_1M = 2'h0,
    RATE_2M = 2'h1,
    RATE_5M5 = 2'h2,
    RATE_11M = 2'h3
  } dsm_rate_t;
  typedef enum logic [1:0] {
    SEG_PREAMBLE = 2'h0,
    SEG_HEADER = 2'h1,
    SEG_PAYLOAD = 2'h2
  } dsm_seg_t;
  typedef struct packed {
    dsm_seg_t seg;
    logic data;
  } dsm_bit_t;
  localparam int SAMPLE_W = 12;
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } dsm_iq_t;
  // Bits consumed per symbol in each mode
  localparam logic [3:0] BITS_1M = 4'h1;
  localparam logic [3:0] BITS_2M = 4'h2;
  localparam logic [3:0] BITS_5M5 = 4'h4;
  localparam logic [3:0] BITS_11M = 4'h8;
  // Barker chips, bit set where the chip is -1, index 0 sent first
  localparam logic [10:0] BARKER_NEG = 11'h712;
  localparam logic [3:0] BARKER_LAST = 4'hA;
  localparam logic [3:0] CCK_LAST = 4'h7;
  // Phase in quarter turns
  localparam logic [1:0] PH_ZERO = 2'h0;
  localparam logic [1:0] PH_QUARTER = 2'h1;
  localparam logic [1:0] PH_HALF = 2'h2;
  localparam logic [2:0] CCK_NEG_A = 3'h3;
  localparam logic [2:0] CCK_NEG_B = 3'h6;
  localparam int FIR_TAPS = 8;
  localparam int COEF_W = 8;
  localparam logic signed [COEF_W-1:0] FIR_STD [FIR_TAPS] =
    '{8'h04, 8'h0C, 8'h1C, 8'h30, 8'h30, 8'h1C, 8'h0C, 8'h04};
  localparam logic signed [COEF_W-1:0] FIR_WIDE [FIR_TAPS] =
    '{8'h00, 8'h06, 8'h20, 8'h3C, 8'h3C, 8'h20, 8'h06, 8'h00};
  localparam int PWR_MEAS_W = 6;
  localparam int PWR_LEVEL_W = 7;
endpackage : dsm_pkg
`default_nettype wire

// >>> verif/dsm_symbol_mapper_asserts.sv
`default_nettype none
module dsm_symbol_mapper_asserts #(
  parameter int MEAS_W = dsm_pkg::PWR_MEAS_W,
  parameter int LEVEL_W = dsm_pkg::PWR_LEVEL_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tx_start,
  input wire logic in_valid,
  input wire dsm_pkg::dsm_bit_t in_sym,
  input wire logic in_ready,
  input wire dsm_pkg::dsm_rate_t payload_rate,
  input wire logic header_short,
  input wire logic tx_filter_select_config,
  input wire logic [MEAS_W-1:0] tx_power_adc,
  input wire logic [MEAS_W-1:0] tx_power_measurement,
  input wire logic [LEVEL_W-1:0] tx_power_level_request,
  input wire logic [LEVEL_W-1:0] tx_power_level,
  input wire logic chip_valid,
  input wire logic out_valid,
  input wire dsm_pkg::dsm_iq_t out_iq
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsm_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic take;
  assign take = in_valid && in_ready;
  sequence s_barker;
    chip_valid [*8] ##1 chip_valid [*3] ##1 !chip_valid;
  endsequence
  // Bursts are 8 or 11 chips, never run together
  sequence s_burst_end;
    !chip_valid or (chip_valid [*3] ##1 !chip_valid);
  endsequence
  AST_PREAMBLE_BURST: assert property (take && in_sym.seg == SEG_PREAMBLE |=> s_barker)
    else $error("preamble burst");
  AST_BURST_LEN: assert property ($rose(chip_valid) |-> chip_valid [*8] ##1 s_burst_end)
    else $error("burst length");
  AST_READY_BUSY: assert property (chip_valid |-> !in_ready) else $error("ready in burst");
  AST_READY_GATHER: assert property (!chip_valid && !tx_start |-> in_ready) else $error("not ready");
  AST_START_REFUSE: assert property (tx_start |-> !in_ready) else $error("ready at start");
  AST_CHIP_CAUSE: assert property ($rose(chip_valid) |-> $past(take)) else $error("chip without bit");
  // A chip enters the delay line one clock after it shows and the sum is registered one more
  AST_OUT_RISE: assert property ($rose(chip_valid) |-> ##2 out_valid) else $error("filter late");
  AST_OUT_HOLD: assert property ($fell(chip_valid) |-> out_valid [*7]) else $error("filter drain");
  AST_PWR_MEAS: assert property ($past(resetn, 3) && $past(resetn, 2) && $past(resetn) |->
    tx_power_measurement == $past(tx_power_adc, 3)) else $error("measurement");
  AST_PWR_LEVEL: assert property ($past(resetn) |-> tx_power_level == $past(tx_power_level_request))
    else $error("level");
endmodule // dsm_symbol_mapper_asserts
bind dsm_symbol_mapper dsm_symbol_mapper_asserts #(.MEAS_W(MEAS_W), .LEVEL_W(LEVEL_W)) dsm_sva_inst (.*);
`default_nettype wire

// >>> verif/dsm_mac_model.sv
`default_nettype none
module dsm_mac_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  input wire logic in_ready,
  input wire logic [5:0] tx_power_measurement,
  input wire logic [6:0] target,
  output logic in_valid,
  output dsm_pkg::dsm_bit_t in_sym,
  output logic [6:0] tx_power_level_request
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsm_pkg::*;
  dsm_bit_t q[$];
  task automatic push(input dsm_bit_t b);
    q.push_back(b);
  endtask
  // An offer holds until taken; idle data toggles so stale bits never look valid
  always @(posedge clk_sys) begin
    if (!resetn) begin
      in_valid <= 1'b0;
      in_sym <= '0;
      tx_power_level_request <= '0;
    end else begin
      tx_power_level_request <= ({1'b0, tx_power_measurement} < target) ? tx_power_level_request + 7'h1 :
        tx_power_level_request - 7'h1;
      if (!in_valid || in_ready) begin
        in_valid <= q.size() > 0 && !stall;
        in_sym <= (q.size() > 0 && !stall) ? q.pop_front() : ~in_sym;
      end
    end
  end
endmodule // dsm_mac_model
`default_nettype wire

// >>> verif/dsm_symbol_mapper_tb.sv
`default_nettype none
module dsm_symbol_mapper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dsm_pkg::*;
  logic clk_sys = 0, resetn = 0, tx_start = 0, stall = 0, header_short = 0, tx_filter_select_config = 0;
  logic in_valid, in_ready, chip_valid, out_valid, ev_ov = 0;
  dsm_bit_t in_sym;
  dsm_rate_t payload_rate = RATE_1M;
  logic [5:0] tx_power_adc = '0, tx_power_measurement;
  logic [6:0] tx_power_level_request, tx_power_level, target = '0;
  dsm_iq_t out_iq;
  logic [23:0] ev_iq = '0;
  logic [31:0] seed = 32'hbab3_6bb3;
  int fails = 0, checked = 0, ph = 0, cnt = 0, md = 0, pl = 0, tp[8], bq[$], cq[$], ah[$], rh[$];
  dsm_symbol_mapper dsm_symbol_mapper_inst (.*);
  dsm_mac_model dsm_mac_model_inst (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
  always @(posedge clk_sys) begin
    tx_power_adc <= 6'(xs());
    target <= 7'(xs() >> 8);
    stall <= 1'(xs() >> 3);
  end
  // Reference model runs at the falling edge, where every port has settled
  always @(negedge clk_sys) begin : model
    int c, si, sq, co, p2, p3, p4;
    if (!resetn) begin
      foreach (tp[k]) tp[k] = -1;
      bq.delete();
      cq.delete();
      ah.delete();
      rh.delete();
      {ph, cnt, ev_iq, ev_ov} = '0;
    end else begin
      chk("chip_valid", cq.size() > 0, chip_valid);
      chk("in_ready", cq.size() == 0 && !tx_start, in_ready);
      chk("out_valid", ev_ov, out_valid);
      chk("out_iq", ev_iq, out_iq);
      if (ah.size() >= 3) chk("measurement", 24'(ah[$-2]), tx_power_measurement);
      if (rh.size() > 0) chk("level", 24'(rh[$]), tx_power_level);
      ah.push_back(tx_power_adc);
      rh.push_back(tx_power_level_request);
      // Taps as the delay line holds them now; their registered sum shows one clock later
      {si, sq, ev_ov} = '0;
      foreach (tp[k]) if (tp[k] >= 0) begin
        co = tx_filter_select_config ? FIR_WIDE[k] : FIR_STD[k];
        si += (tp[k] == 1 || tp[k] == 2) ? -co : co;
        sq += (tp[k] >= 2) ? -co : co;
        ev_ov = 1;
      end
      ev_iq = {12'(si), 12'(sq)};
      c = cq.size() > 0 ? cq.pop_front() : -1;
      for (int k = 7; k > 0; k--) tp[k] = tp[k-1];
      tp[0] = c;
      if (tx_start) begin
        bq.delete();
        {ph, cnt} = '0;
      end else if (in_valid && in_ready) begin
        bq.push_back(int'(in_sym.data));
        if (bq.size() == 1) begin
          pl = in_sym.seg == SEG_PAYLOAD;
          md = pl ? int'(payload_rate) : (in_sym.seg == SEG_HEADER && header_short) ? 1 : 0;
        end
        if (bq.size() == (1 << md)) begin
          c = md == 0 ? 2 * bq[0] : bq[0] ? 3 - bq[1] : bq[1];
          if (md < 2) begin
            ph = (ph + c) % 4;
            for (int k = 0; k < 11; k++) cq.push_back((ph + (BARKER_NEG[k] ? 2 : 0)) % 4);
          end else begin
            ph = (ph + c + 2 * (cnt % 2)) % 4;
            p2 = md == 2 ? 2 * bq[2] + 1 : 2 * bq[2] + bq[3];
            p3 = md == 2 ? 0 : 2 * bq[4] + bq[5];
            p4 = md == 2 ? 2 * bq[3] : 2 * bq[6] + bq[7];
            for (int k = 0; k < 8; k++)
              cq.push_back((ph + (k % 2 ? 0 : p2) + (k / 2 % 2 ? 0 : p3) + (k / 4 ? 0 : p4) + (k % 3 ? 0 : 2 * (k > 0))) % 4);
          end
          cnt += pl;
          bq.delete();
        end
      end
    end
  end
  task automatic pkt(input int i);
    int n;
    @(posedge clk_sys);
    tx_start <= 1'b1;
    payload_rate <= dsm_rate_t'(i % 4);
    header_short <= i[2];
    tx_filter_select_config <= i[1] ^ i[2];
    @(posedge clk_sys);
    tx_start <= 1'b0;
    repeat (3) dsm_mac_model_inst.push('{SEG_PREAMBLE, 1'(xs())});
    repeat (4) dsm_mac_model_inst.push('{SEG_HEADER, 1'(xs())});
    repeat (3 << (i % 4)) dsm_mac_model_inst.push('{SEG_PAYLOAD, 1'(xs())});
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((in_valid || chip_valid || out_valid || dsm_mac_model_inst.q.size() > 0) && n < 3000);
    chk("drain", 24'h0, 24'(n >= 3000));
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) pkt(i);
    results();
  end
endmodule // dsm_symbol_mapper_tb
`default_nettype wire
